// *** src/flash_secure_defines.svh ***
`ifndef FLASH_SECURE_DEFINES_SVH
`define FLASH_SECURE_DEFINES_SVH

`define ADDR_W            24
`define DATA_W            16
`define PIN_RESET         7'h7F
`define UNLOCK1_ADDR      12'h555
`define UNLOCK2_ADDR      12'h2AA
`define CMD_UNLOCK1       16'h00AA
`define CMD_UNLOCK2       16'h0055
`define CMD_SEC_ENTRY     16'h0088
`define CMD_SEC_EXIT      16'h0090
`define CMD_EXIT_FINAL    16'h0000
`define CMD_PROG_SETUP    16'h00A0
`define CMD_CUST_LOCK     16'h0060
`define CMD_BYPASS        16'h0020
`define SEC_TOP_BITS      16
`define SECTOR0_HI_BITS   10
`define LOCK_OFFSET       8'h03
`define FACTORY_LOCK_BIT  7
`define CUSTOMER_LOCK_BIT 6
`define INVALID_WORD      16'hFFFF
`define ERASED_WORD       16'hFFFF
`define CLK_PERIOD_NS     10
`define ACCESS_TIME_NS    70
`define SLEEP_MARGIN_NS   20
`define SLEEP_CYCLES      8'(((`ACCESS_TIME_NS + `SLEEP_MARGIN_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_PULSE_NS    50
`define CLEAR_CYCLES      8'((`CLEAR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_TIME_NS      1000
`define PROG_CYCLES       12'((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** src/flash_secure_pkg.sv ***
package flash_secure_pkg;

    typedef enum logic [2:0]
    {
        CMD_IDLE,
        CMD_UNLK1,
        CMD_UNLK2,
        CMD_ASEL,
        CMD_PSETUP
    } cmd_state_t;

endpackage

// *** src/flash_secure_region_and_power_ctrl.sv ***
`timescale 1ns/1ns
`include "flash_secure_defines.svh"
module flash_secure_region_and_power_ctrl
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                burst_clk,
    input  wire logic                ce_b,
    input  wire logic                oe_b,
    input  wire logic                we_b,
    input  wire logic                adv_b,
    input  wire logic                reset_pin_b,
    input  wire logic                wp_b,
    input  wire logic                accelerated_program_input,
    input  wire logic [`ADDR_W-1:0]  addr,
    input  wire logic [`DATA_W-1:0]  data_in,
    input  wire logic [`DATA_W-1:0]  array_rd_data,
    input  wire logic                array_busy,
    input  wire logic                cfg_wr,
    input  wire logic                cfg_sync_bit,
    output logic      [`DATA_W-1:0]  data_out,
    output logic                     data_oe,
    output logic      [`ADDR_W-1:0]  array_rd_addr,
    output logic                     standby,
    output logic                     auto_sleep,
    output logic                     sync_mode,
    output logic                     secure_mode,
    output logic                     bank0_blocked,
    output logic                     prog_busy
);

    function automatic logic in_region(input logic [`ADDR_W-1:0] a);
        in_region = (a[`ADDR_W-1:8] == `SEC_TOP_BITS'(0));
    endfunction

    // link domain: one toggle per rising burst clock edge inside a burst frame
    logic burst_tog;
    always_ff @(posedge burst_clk or negedge rst_b)
    begin
        if (!rst_b)
            burst_tog <= 1'b0;
        else if (!ce_b && adv_b)
            burst_tog <= ~burst_tog;
    end

    logic [2:0] tog_sync;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tog_sync <= 3'h0;
        else
            tog_sync <= {tog_sync[1:0], burst_tog};
    end
    wire burst_step = tog_sync[2] ^ tog_sync[1];

    // pins are asynchronous to clk; wide buses are held stable around
    // the strobes, so a plain two-stage sample is enough
    logic [6:0]         pin_s1;
    logic [6:0]         pin_s2;
    logic [`ADDR_W-1:0] addr_s1;
    logic [`ADDR_W-1:0] addr_s;
    logic [`DATA_W-1:0] din_s1;
    logic [`DATA_W-1:0] din_s;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1  <= `PIN_RESET;
            pin_s2  <= `PIN_RESET;
            addr_s1 <= `ADDR_W'(0);
            addr_s  <= `ADDR_W'(0);
            din_s1  <= `DATA_W'(0);
            din_s   <= `DATA_W'(0);
        end
        else
        begin
            pin_s1  <= {accelerated_program_input, wp_b, reset_pin_b,
                        adv_b, we_b, oe_b, ce_b};
            pin_s2  <= pin_s1;
            addr_s1 <= addr;
            addr_s  <= addr_s1;
            din_s1  <= data_in;
            din_s   <= din_s1;
        end
    end

    wire ce_s      = pin_s2[0];
    wire oe_s      = pin_s2[1];
    wire we_s      = pin_s2[2];
    wire adv_s     = pin_s2[3];
    wire rst_pin_s = pin_s2[4];
    wire wp_s      = pin_s2[5];
    wire acc_s     = pin_s2[6];

    flash_secure_pkg::cmd_state_t state;
    flash_secure_pkg::cmd_state_t next_state;
    logic                 we_prev;
    logic [7:0]           clr_cnt;
    logic [11:0]          prog_cnt;
    logic [7:0]           prog_ofs;
    logic [`DATA_W-1:0]   prog_data;
    logic                 cust_lock;
    logic                 next_secure;
    logic                 next_cust_lock;
    logic                 start_prog;
    logic [`ADDR_W-1:0]   burst_addr;
    logic [`ADDR_W-1:0]   addr_last;
    logic [7:0]           stable_cnt;
    logic [`DATA_W-1:0]   sec_mem [0:255];
    logic [255:0]         sec_written;

    // hardware reset pin: commands ignored while low, clear once held
    wire hw_clear  = !rst_pin_s && (clr_cnt == `CLEAR_CYCLES);
    wire we_rise   = we_s && !we_prev && !ce_s && rst_pin_s && !prog_busy;
    wire busy_now  = prog_busy || array_busy;
    wire at_u1     = (addr_s[11:0] == `UNLOCK1_ADDR);
    wire at_u2     = (addr_s[11:0] == `UNLOCK2_ADDR);
    wire cust_tgt  = in_region(addr_s) && addr_s[7];
    wire prog_ok   = secure_mode && cust_tgt && !cust_lock && wp_s
                     && acc_s && !busy_now;

    always_comb
    begin
        next_state     = state;
        next_secure    = secure_mode;
        next_cust_lock = cust_lock;
        start_prog     = 1'b0;
        if (we_rise)
        begin
            next_state = flash_secure_pkg::CMD_IDLE;
            case (state)
                flash_secure_pkg::CMD_IDLE:
                    if (at_u1 && din_s == `CMD_UNLOCK1)
                        next_state = flash_secure_pkg::CMD_UNLK1;
                flash_secure_pkg::CMD_UNLK1:
                    if (at_u2 && din_s == `CMD_UNLOCK2)
                        next_state = flash_secure_pkg::CMD_UNLK2;
                flash_secure_pkg::CMD_UNLK2:
                    if (at_u1)
                    begin
                        case (din_s)
                            `CMD_SEC_ENTRY:
                                next_secure = secure_mode || !busy_now;
                            `CMD_SEC_EXIT:
                                next_state = flash_secure_pkg::CMD_ASEL;
                            `CMD_PROG_SETUP:
                                if (secure_mode)
                                    next_state = flash_secure_pkg::CMD_PSETUP;
                            `CMD_CUST_LOCK:
                                if (secure_mode && !busy_now && wp_s && acc_s)
                                    next_cust_lock = 1'b1;
                            default:
                                next_state = flash_secure_pkg::CMD_IDLE;
                        endcase
                    end
                flash_secure_pkg::CMD_ASEL:
                    if (din_s == `CMD_EXIT_FINAL)
                        next_secure = 1'b0;
                flash_secure_pkg::CMD_PSETUP:
                    start_prog = prog_ok;
                default:
                    next_state = flash_secure_pkg::CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state       <= flash_secure_pkg::CMD_IDLE;
            secure_mode <= 1'b0;
            cust_lock   <= 1'b0;
            we_prev     <= 1'b1;
            clr_cnt     <= 8'h00;
        end
        else if (hw_clear)
        begin
            state       <= flash_secure_pkg::CMD_IDLE;
            secure_mode <= 1'b0;
            we_prev     <= we_s;
        end
        else
        begin
            state       <= next_state;
            secure_mode <= next_secure;
            cust_lock   <= next_cust_lock;
            we_prev     <= we_s;
            clr_cnt     <= rst_pin_s ? 8'h00 : clr_cnt + 8'h01;
        end
    end

    // the customer lock is nonvolatile: only power loss clears it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_busy <= 1'b0;
            prog_cnt  <= 12'h000;
            prog_ofs  <= 8'h00;
            prog_data <= 16'h0000;
        end
        else if (hw_clear)
            prog_busy <= 1'b0;
        else if (start_prog)
        begin
            // plain timing only: no accelerated path for this region
            prog_busy <= 1'b1;
            prog_cnt  <= `PROG_CYCLES;
            prog_ofs  <= addr_s[7:0];
            prog_data <= din_s;
        end
        else if (prog_busy)
        begin
            prog_cnt  <= prog_cnt - 12'h001;
            prog_busy <= (prog_cnt != 12'h001);
        end
    end

    wire prog_done = prog_busy && (prog_cnt == 12'h001) && !hw_clear;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sec_written <= 256'h0;
        else if (prog_done)
            sec_written[prog_ofs] <= 1'b1;
    end

    // flash cells only clear bits; data is merged into what is stored
    always_ff @(posedge clk)
    begin
        if (prog_done)
            sec_mem[prog_ofs] <= sec_written[prog_ofs]
                ? (sec_mem[prog_ofs] & prog_data) : prog_data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sync_mode <= 1'b0;
        else if (hw_clear)
            sync_mode <= 1'b0;
        else if (cfg_wr)
            sync_mode <= cfg_sync_bit;
    end

    // burst address: in secure mode, bursts in sector 0 wrap inside their own 256-word block
    wire in_sec_map = secure_mode
                      && (burst_addr[`ADDR_W-1:14] == `SECTOR0_HI_BITS'(0));
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            burst_addr <= `ADDR_W'(0);
        else if (!adv_s && !ce_s)
            burst_addr <= addr_s;
        else if (burst_step && in_sec_map)
            burst_addr[7:0] <= burst_addr[7:0] + 8'h01;
        else if (burst_step)
            burst_addr <= burst_addr + `ADDR_W'(1);
    end

    wire [`ADDR_W-1:0] rd_addr  = sync_mode ? burst_addr : addr_s;
    wire               sec_hit  = secure_mode
                         && (rd_addr[`ADDR_W-1:14] == `SECTOR0_HI_BITS'(0));
    wire [`DATA_W-1:0] sec_word =
        (busy_now || !in_region(rd_addr)) ? `INVALID_WORD
        : !sec_written[rd_addr[7:0]] ? `ERASED_WORD
        : sec_mem[rd_addr[7:0]];
    wire [`DATA_W-1:0] lock_word =
        (`DATA_W'(1) << `FACTORY_LOCK_BIT)
        | (`DATA_W'(cust_lock) << `CUSTOMER_LOCK_BIT);
    wire [`DATA_W-1:0] asel_word =
        (rd_addr[7:0] == `LOCK_OFFSET) ? lock_word : `INVALID_WORD;
    wire is_asel = (state == flash_secure_pkg::CMD_ASEL);
    // outside the autoselect state, other banks and other sectors keep reading the array
    wire [`DATA_W-1:0] read_word = is_asel ? asel_word
        : sec_hit ? sec_word : array_rd_data;

    wire addr_moved = (addr_s != addr_last);
    wire main_read  = !sync_mode && !sec_hit && !is_asel
                      && (state == flash_secure_pkg::CMD_IDLE);
    wire drive      = !ce_s && !oe_s && rst_pin_s;
    wire hold_out   = auto_sleep && main_read && !addr_moved;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_last  <= `ADDR_W'(0);
            stable_cnt <= 8'h00;
            auto_sleep <= 1'b0;
        end
        else
        begin
            addr_last  <= addr_s;
            // restart on any change of read source, so no stale word latches
            if (addr_moved || !main_read)
                stable_cnt <= 8'h00;
            else if (stable_cnt != `SLEEP_CYCLES)
                stable_cnt <= stable_cnt + 8'h01;
            auto_sleep <= main_read && !addr_moved
                          && (stable_cnt == `SLEEP_CYCLES);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_out      <= `DATA_W'(0);
            data_oe       <= 1'b0;
            array_rd_addr <= `ADDR_W'(0);
            standby       <= 1'b0;
            bank0_blocked <= 1'b0;
        end
        else
        begin
            if (!hold_out)
                data_out  <= read_word;
            data_oe       <= drive;
            array_rd_addr <= rd_addr;
            standby       <= ce_s && rst_pin_s && !busy_now;
            bank0_blocked <= secure_mode;
        end
    end

    sequence s_exit_final;
        is_asel && we_rise && (din_s == `CMD_EXIT_FINAL) && !hw_clear;
    endsequence

    sequence s_entry_cmd;
        (state == flash_secure_pkg::CMD_UNLK2) && we_rise && at_u1
        && (din_s == `CMD_SEC_ENTRY) && !busy_now && !hw_clear;
    endsequence

    property p_standby_float;
        @(posedge clk) disable iff (!rst_b)
        standby |-> !data_oe;
    endproperty
    a_standby_float: assert property (p_standby_float)
        else $error("outputs driven in standby");

    property p_standby_waits;
        @(posedge clk) disable iff (!rst_b)
        (ce_s && busy_now) |=> !standby;
    endproperty
    a_standby_waits: assert property (p_standby_waits)
        else $error("standby entered while busy");

    property p_sleep_needs_stable;
        @(posedge clk) disable iff (!rst_b)
        addr_moved |=> !auto_sleep [*8];
    endproperty
    a_sleep_needs_stable: assert property (p_sleep_needs_stable)
        else $error("sleep entered too early");

    property p_sleep_holds_data;
        @(posedge clk) disable iff (!rst_b)
        (auto_sleep && $past(auto_sleep)) |-> $stable(data_out);
    endproperty
    a_sleep_holds_data: assert property (p_sleep_holds_data)
        else $error("data changed during sleep");

    property p_no_sync_sleep;
        @(posedge clk) disable iff (!rst_b)
        sync_mode |=> !auto_sleep;
    endproperty
    a_no_sync_sleep: assert property (p_no_sync_sleep)
        else $error("sleep in synchronous mode");

    property p_hw_clear;
        @(posedge clk) disable iff (!rst_b)
        hw_clear |=> (!secure_mode && !sync_mode && !prog_busy
                      && state == flash_secure_pkg::CMD_IDLE);
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("hardware reset did not clear state");

    property p_oe_float;
        @(posedge clk) disable iff (!rst_b)
        oe_s |=> !data_oe;
    endproperty
    a_oe_float: assert property (p_oe_float)
        else $error("outputs driven with output enable high");

    property p_entry;
        @(posedge clk) disable iff (!rst_b)
        s_entry_cmd |=> secure_mode ##1 bank0_blocked;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry sequence did not enter secure mode");

    property p_exit;
        @(posedge clk) disable iff (!rst_b)
        s_exit_final |=> !secure_mode && state == flash_secure_pkg::CMD_IDLE;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit sequence did not leave secure mode");

    property p_lock_sticky;
        @(posedge clk) disable iff (!rst_b)
        cust_lock |=> cust_lock && !start_prog;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("customer lock lost or bypassed");

    property p_wp_blocks;
        @(posedge clk) disable iff (!rst_b)
        (!wp_s || !addr_s[7]) |-> !start_prog;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks)
        else $error("protected word programming started");

    property p_busy_refuse;
        @(posedge clk) disable iff (!rst_b)
        (busy_now && sec_hit && !is_asel && !hw_clear)
            |=> data_out == `INVALID_WORD;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("secure region readable while busy");

    property p_wrap;
        @(posedge clk) disable iff (!rst_b)
        (burst_step && in_sec_map && adv_s && burst_addr[7:0] == 8'hFF)
            |=> burst_addr[7:0] == 8'h00
                && burst_addr[`ADDR_W-1:8] == $past(burst_addr[`ADDR_W-1:8]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("secure burst did not wrap");

endmodule

// *** testbench/flash_array_model.sv ***
`timescale 1ns/1ns
module flash_array_model
(
    input  wire logic [23:0] rd_addr,
    output logic      [15:0] rd_data
);
    // word keyed on address bits 15:0, so a stale word passes for a new one only when those bits match
    assign rd_data = rd_addr[15:0] ^ 16'hA5C3;
endmodule

// *** testbench/test_flash_secure_region_and_power_ctrl.sv ***
`timescale 1ns/1ns
`include "flash_secure_defines.svh"
module test_flash_secure_region_and_power_ctrl;
    logic        clk, rst_b, burst_clk, ce_b, oe_b, we_b, adv_b;
    logic        reset_pin_b, wp_b, acc, array_busy, cfg_wr, cfg_sync_bit;
    logic [23:0] addr, array_rd_addr;
    logic [15:0] data_in, data_out, array_rd_data;
    logic        data_oe, standby, auto_sleep, sync_mode;
    logic        secure_mode, bank0_blocked, prog_busy;
    int          n_errors = 0;
    int          tests_run = 0;

    flash_secure_region_and_power_ctrl dut
    (
        .clk(clk), .rst_b(rst_b), .burst_clk(burst_clk), .ce_b(ce_b),
        .oe_b(oe_b), .we_b(we_b), .adv_b(adv_b), .reset_pin_b(reset_pin_b),
        .wp_b(wp_b), .accelerated_program_input(acc), .addr(addr),
        .data_in(data_in), .array_rd_data(array_rd_data),
        .array_busy(array_busy), .cfg_wr(cfg_wr),
        .cfg_sync_bit(cfg_sync_bit), .data_out(data_out),
        .data_oe(data_oe), .array_rd_addr(array_rd_addr),
        .standby(standby), .auto_sleep(auto_sleep), .sync_mode(sync_mode),
        .secure_mode(secure_mode), .bank0_blocked(bank0_blocked),
        .prog_busy(prog_busy)
    );

    flash_array_model array_side
    (
        .rd_addr(array_rd_addr),
        .rd_data(array_rd_data)
    );

    function automatic logic [15:0] arr(input logic [23:0] a);
        return a[15:0] ^ 16'hA5C3;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // pins held steady well past the sync depth on both sides of the rise
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        data_in <= d;
        ce_b <= 1'b0;
        tick(3);
        @(posedge clk);
        we_b <= 1'b0;
        tick(4);
        @(posedge clk);
        we_b <= 1'b1;
        tick(6);
    endtask

    task automatic rd(input logic [23:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        ce_b <= 1'b0;
        oe_b <= 1'b0;
        tick(6);
        chk(data_out, exp);
    endtask

    task automatic unlk(input logic [15:0] cmd);
        wr(24'h000555, 16'h00AA);
        wr(24'h0002AA, 16'h0055);
        wr(24'h000555, cmd);
    endtask

    task automatic prog(input logic [23:0] a, input logic [15:0] d);
        int i;
        unlk(16'h00A0);
        wr(a, d);
        for (i = 0; i < 300 && prog_busy !== 1'b0; i++)
            tick(1);
    endtask

    task automatic cfg(input logic b);
        @(posedge clk);
        cfg_sync_bit <= b;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        tick(2);
    endtask

    // link clock runs only inside a burst, off phase from clk
    task automatic bedge(input int n);
        #3;
        repeat (n)
        begin
            #40 burst_clk = 1'b1;
            #40 burst_clk = 1'b0;
        end
    endtask

    task automatic t_power;
        tick(5);
        chk(16'(standby), 16'h0001);
        chk(16'(data_oe), 16'h0000);
        @(posedge clk);
        addr <= 24'h004000;
        ce_b <= 1'b0;
        tick(6);
        chk(16'(data_oe), 16'h0000);
        rd(24'h004000, arr(24'h004000));
        chk(16'(data_oe), 16'h0001);
        $display("test power done");
    endtask

    task automatic t_sleep;
        @(posedge clk);
        addr <= 24'h004200;
        tick(7);
        chk(16'(auto_sleep), 16'h0000);
        tick(10);
        chk(16'(auto_sleep), 16'h0001);
        chk(data_out, arr(24'h004200));
        cfg(1'b1);
        tick(25);
        chk(16'(auto_sleep), 16'h0000);
        cfg(1'b0);
        $display("test sleep done");
    endtask

    task automatic t_entry;
        @(posedge clk);
        array_busy <= 1'b1;
        unlk(16'h0088);
        chk(16'(secure_mode), 16'h0000);
        @(posedge clk);
        array_busy <= 1'b0;
        unlk(16'h0088);
        chk(16'(secure_mode), 16'h0001);
        chk(16'(bank0_blocked), 16'h0001);
        rd(24'h000000, 16'hFFFF);
        rd(24'h000100, 16'hFFFF);
        rd(24'h004000, arr(24'h004000));
        wr(24'h000555, 16'h00AA);
        wr(24'h0002AA, 16'h1234);
        unlk(16'h0020);
        wr(24'h000000, 16'h0000);
        chk(16'(secure_mode), 16'h0001);
        $display("test entry done");
    endtask

    task automatic t_prog;
        int i;
        unlk(16'h00A0);
        wr(24'h000080, 16'h1234);
        chk(16'(prog_busy), 16'h0001);
        @(posedge clk);
        ce_b <= 1'b1;
        tick(5);
        chk(16'(standby), 16'h0000);
        // writes are refused while busy; let the program end deselected
        for (i = 0; i < 300 && prog_busy !== 1'b0; i++)
            tick(1);
        tick(3);
        chk(16'(standby), 16'h0001);
        rd(24'h000080, 16'h1234);
        prog(24'h000010, 16'h0000);
        rd(24'h000010, 16'hFFFF);
        wp_b <= 1'b0;
        prog(24'h000081, 16'h0000);
        rd(24'h000081, 16'hFFFF);
        wp_b <= 1'b1;
        acc <= 1'b0;
        prog(24'h000082, 16'h0000);
        rd(24'h000082, 16'hFFFF);
        acc <= 1'b1;
        $display("test program done");
    endtask

    task automatic t_lock;
        unlk(16'h0090);
        rd(24'h000003, 16'h0080);
        chk(16'(data_out[7:6]), 16'h0002);
        wr(24'h000000, 16'h0000);
        chk(16'(secure_mode), 16'h0000);
        unlk(16'h0088);
        unlk(16'h0060);
        unlk(16'h0090);
        rd(24'h000003, 16'h00C0);
        chk(16'(data_out[7:6]), 16'h0003);
        wr(24'h000123, 16'h0000);
        chk(16'(secure_mode), 16'h0000);
        unlk(16'h0088);
        prog(24'h000083, 16'h0000);
        rd(24'h000083, 16'hFFFF);
        rd(24'h000080, 16'h1234);
        $display("test lock done");
    endtask

    task automatic t_burst;
        cfg(1'b1);
        @(posedge clk);
        addr <= 24'h00007F;
        adv_b <= 1'b0;
        tick(4);
        @(posedge clk);
        adv_b <= 1'b1;
        tick(4);
        bedge(1);
        tick(8);
        chk(data_out, 16'h1234);
        // a full lap of the region lands back on the programmed word
        bedge(256);
        tick(8);
        chk(data_out, 16'h1234);
        $display("test burst done");
    endtask

    task automatic t_hwreset;
        @(posedge clk);
        reset_pin_b <= 1'b0;
        tick(5);
        chk(16'(data_oe), 16'h0000);
        tick(4);
        @(posedge clk);
        reset_pin_b <= 1'b1;
        tick(5);
        chk(16'(secure_mode), 16'h0000);
        chk(16'(sync_mode), 16'h0000);
        rd(24'h000000, arr(24'h000000));
        unlk(16'h0088);
        chk(16'(secure_mode), 16'h0001);
        $display("test hwreset done");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // all scenarios fit well inside forty thousand cycles
    initial
    begin
        #400000;
        n_errors++;
        conclude;
    end

    initial
    begin
        rst_b = 1'b0;
        burst_clk = 1'b0;
        ce_b = 1'b1;
        oe_b = 1'b1;
        we_b = 1'b1;
        adv_b = 1'b1;
        reset_pin_b = 1'b1;
        wp_b = 1'b1;
        acc = 1'b1;
        array_busy = 1'b0;
        cfg_wr = 1'b0;
        cfg_sync_bit = 1'b0;
        addr = 24'h000000;
        data_in = 16'h0000;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        tick(3);
        t_power;
        t_sleep;
        t_entry;
        t_prog;
        t_lock;
        t_burst;
        t_hwreset;
        conclude;
    end
endmodule
